/* hdl/pbo_ovr_if.sv */
`timescale 1ns/1ns
`default_nettype none
// override enables and values, one bit per pin
interface pbo_ovr_if #(
  parameter int unsigned N = 6
);
  logic [N-1:0] pullup_override_enable;
  logic [N-1:0] pullup_override_value;
  logic [N-1:0] direction_override_enable;
  logic [N-1:0] direction_override_value;
  logic [N-1:0] port_value_override_enable;
  logic [N-1:0] port_value_override_value;
  logic [N-1:0] toggle_override_enable;
  logic [N-1:0] input_enable_override_enable;
  logic [N-1:0] input_enable_override_value;

  modport src (
    output pullup_override_enable, pullup_override_value,
    output direction_override_enable, direction_override_value,
    output port_value_override_enable, port_value_override_value,
    output toggle_override_enable,
    output input_enable_override_enable, input_enable_override_value
  );
  modport pin (
    input pullup_override_enable, pullup_override_value,
    input direction_override_enable, direction_override_value,
    input port_value_override_enable, port_value_override_value,
    input toggle_override_enable,
    input input_enable_override_enable, input_enable_override_value
  );
endinterface
`default_nettype wire

/* hdl/pbo_pin_ctl.sv */
`timescale 1ns/1ns
`default_nettype none
// per-pin resolution of overrides against the register bits
module pbo_pin_ctl
  import pbo_pkg::*;
#(
  parameter int unsigned N = PIN_COUNT
) (
  pbo_ovr_if.pin          ovr,            // override bundle
  input  wire logic [N-1:0] pin_direction_i, // direction register bits
  input  wire logic [N-1:0] pin_output_i,  // output register bits
  input  wire logic         pullup_off_i,  // global pull-up disable
  input  wire logic         sleep_i,       // deep sleep clamp request
  input  wire logic [N-1:0] pad_i,         // pad level
  output logic      [N-1:0] pad_o,         // pad drive value
  output logic      [N-1:0] pad_oe_o,      // pad driver enable
  output logic      [N-1:0] pullup_o,      // pull-up enable
  output logic      [N-1:0] din_o          // digital input to peripherals
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic port_bit;
      logic in_en;
      // toggle override inverts the stored bit before use
      assign port_bit = pin_output_i[g] ^ ovr.toggle_override_enable[g];
      // pull-up: override, else input with bit high and not globally disabled
      assign pullup_o[g] = ovr.pullup_override_enable[g] ?
                           ovr.pullup_override_value[g] :
                           (~pin_direction_i[g] & port_bit & ~pullup_off_i); // RQ14 RQ11
      assign pad_oe_o[g] = ovr.direction_override_enable[g] ?
                           ovr.direction_override_value[g] : pin_direction_i[g]; // RQ15
      assign pad_o[g] = ovr.port_value_override_enable[g] ?
                        ovr.port_value_override_value[g] : port_bit; // RQ16
      // input clamp follows sleep unless an alternate function needs it
      assign in_en = ovr.input_enable_override_enable[g] ?
                     ovr.input_enable_override_value[g] : ~sleep_i; // RQ17
      assign din_o[g] = pad_i[g] & in_en;
    end
  endgenerate
endmodule
`default_nettype wire

/* hdl/pbo_pkg.sv */
`default_nettype none
package pbo_pkg;
  // port geometry
  localparam int unsigned PIN_COUNT   = 6;
  localparam int unsigned REG_WIDTH   = 8;
  localparam int unsigned WB_AW       = 4;
  localparam int unsigned WB_DW       = 32;
  localparam int unsigned ADC_CHANNELS = 4;

  // pin roles
  localparam int unsigned PIN_TOP     = 5;
  localparam int unsigned PIN_CH2     = 4;
  localparam int unsigned PIN_CH3     = 3;
  localparam int unsigned PIN_TIMER   = 2;
  localparam int unsigned PIN_CMP_NEG = 1;
  localparam int unsigned PIN_CMP_POS = 0;

  // analog channel numbers
  localparam int unsigned CH0 = 0;
  localparam int unsigned CH1 = 1;
  localparam int unsigned CH2 = 2;
  localparam int unsigned CH3 = 3;

  // register byte addresses
  localparam logic [WB_AW-1:0] ADDR_MCU_CONTROL = 4'h0;
  localparam logic [WB_AW-1:0] ADDR_PORT_OUTPUT = 4'h4;
  localparam logic [WB_AW-1:0] ADDR_DIRECTION   = 4'h8;
  localparam logic [WB_AW-1:0] ADDR_PIN_INPUT   = 4'hC;

  // field layout and reset values
  localparam int unsigned         PULLUP_DISABLE_BIT = 6;
  localparam logic [REG_WIDTH-1:0] MCU_WR_MASK       = 8'h7B;
  localparam logic [REG_WIDTH-1:0] MCU_RESET         = 8'h00;
  localparam logic [PIN_COUNT-1:0] PORT_RESET        = 6'h00;
  localparam logic [PIN_COUNT-1:0] DIR_RESET         = 6'h00;

  // a fuse reads zero when programmed
  localparam logic FUSE_PROGRAMMED = 1'b0;
endpackage
`default_nettype wire

/* hdl/pbo_top.sv */
// Summary of operation
// RQ1: top pin, both fuses programmed: pull-up on, direction from debug transmit.
// RQ2: a fuse term is one when its stored value is zero.
// RQ3: top pin input override: reset disabled, masked pin change, or analog0 disable.
// RQ4: pins four to two input override: masked pin change or analog disable.
// RQ5: pins one and zero input override: masked pin change or comparator disable.
// RQ6: pins one and zero port value from timer compare B and A outputs.
// RQ7: all other pull-up, direction, toggle and port overrides stay zero.
// RQ8: pin two input feeds timer clock, interrupt zero and pin change two.
// RQ9: top pin carries reset, debug I/O, analog channel 0 and pin change five.
// RQ10: pin three clock and channel 3; pins zero/one feed comparator inputs.
// RQ11: global pull-up disable turns off every pull-up except the top pin pull-up forced on in debug mode.
// RQ12: control register bits 7 and 2 read zero; others read-write, reset zero.
// RQ13: output register bits 5..0 read-write, reset zero; bits 7,6 read zero.
// RQ14: pull-up follows override value, else input, bit high, not disabled.
// RQ15: driver enable follows override value, else direction bit.
// RQ16: driven value is override value when enabled, else output bit.
// RQ17: input enable follows override value when enabled, else sleep state.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module pbo_top
  import pbo_pkg::*;
#(
  parameter int unsigned N = PIN_COUNT
) (
  input  wire logic             clk_i,         // i/o clock
  input  wire logic             rst_i,         // synchronous reset, high
  // wishbone slave
  input  wire logic             wb_cyc_i,      // cycle
  input  wire logic             wb_stb_i,      // strobe
  input  wire logic             wb_we_i,       // write
  input  wire logic [WB_AW-1:0] wb_adr_i,      // byte address
  input  wire logic [3:0]       wb_sel_i,      // byte lanes
  input  wire logic [WB_DW-1:0] wb_dat_i,      // write data
  output logic      [WB_DW-1:0] wb_dat_o,      // read data
  output logic                  wb_ack_o,      // acknowledge
  // fuses, stored values
  input  wire logic             reset_pin_disable_fuse_i, // zero = programmed
  input  wire logic             debug_link_enable_fuse_i, // zero = programmed
  // peripheral control
  input  wire logic             debug_link_tx_i,   // debug transmit drive
  input  wire logic [N-1:0]     pin_change_mask_i, // per-source mask
  input  wire logic             pin_change_enable_i, // pin change enable
  input  wire logic [ADC_CHANNELS-1:0] analog_digital_disable_i, // per channel
  input  wire logic             comparator_pos_digital_disable_i, // pin 0
  input  wire logic             comparator_neg_digital_disable_i, // pin 1
  input  wire logic             timer_compare_a_enable_i, // compare A drives pin
  input  wire logic             timer_compare_a_output_i, // compare A waveform
  input  wire logic             timer_compare_b_enable_i, // compare B drives pin
  input  wire logic             timer_compare_b_output_i, // compare B waveform
  input  wire logic             sleep_i,           // deep sleep clamp
  // pads
  input  wire logic [N-1:0]     pad_i,         // pad level
  output logic      [N-1:0]     pad_o,         // pad drive value
  output logic      [N-1:0]     pad_oe_o,      // pad driver enable, high drives
  output logic      [N-1:0]     pullup_o,      // pull-up enable
  // routed inputs
  output logic      [N-1:0]     pin_change_src_o,        // pin change sources
  output logic                  timer_external_clock_o,  // timer clock pin
  output logic                  external_interrupt_zero_o, // interrupt pin
  output logic                  external_clock_input_o,  // system clock pin
  output logic                  debug_link_io_o,         // debug receive
  output logic                  reset_pin_level_o,       // reset analog path
  output logic [ADC_CHANNELS-1:0] analog_channel_o,      // analog paths
  output logic                  comparator_pos_o,        // comparator +
  output logic                  comparator_neg_o,        // comparator -
  output logic                  global_pullup_disable_o  // control bit
);

  typedef struct packed {
    logic                 ack;
    logic [WB_DW-1:0]     rdata;
    logic [REG_WIDTH-1:0] mcu;
    logic [N-1:0]         port;
    logic [N-1:0]         dir;
    logic [N-1:0]         pins;
  } pbo_state_t;

  pbo_state_t state_ff;
  pbo_state_t nxt_state;

  pbo_ovr_if #(.N(N)) ovr ();

  logic [N-1:0] din;
  logic         fuse_rst_off;
  logic         fuse_dbg_on;
  logic         debug_mode;
  logic         req;

  // a stored zero means the fuse is programmed
  function automatic logic fuse_on(input logic stored);
    fuse_on = (stored == FUSE_PROGRAMMED); // RQ2
  endfunction

  // input override term shared by every pin
  function automatic logic input_override(input logic mask, input logic en,
                                          input logic dis);
    input_override = (mask & en) | dis;
  endfunction

  // read decode ignores byte lanes; unmapped reads return zero
  function automatic logic [WB_DW-1:0] reg_read(input pbo_state_t s,
                                                input logic [WB_AW-1:0] a);
    logic [REG_WIDTH-1:0] b;
    b = '0;
    unique case (a)
      ADDR_MCU_CONTROL: b = s.mcu & MCU_WR_MASK; // RQ12
      ADDR_PORT_OUTPUT: b = REG_WIDTH'(s.port); // RQ13
      ADDR_DIRECTION:   b = REG_WIDTH'(s.dir);
      ADDR_PIN_INPUT:   b = REG_WIDTH'(s.pins);
      default:          b = '0;
    endcase
    reg_read = WB_DW'(b);
  endfunction

  assign fuse_rst_off = fuse_on(reset_pin_disable_fuse_i);
  assign fuse_dbg_on  = fuse_on(debug_link_enable_fuse_i);
  assign debug_mode   = fuse_rst_off & fuse_dbg_on;

  // pull-up, direction and toggle overrides: only the debug case is live
  always_comb begin
    ovr.pullup_override_enable    = '0; // RQ7
    ovr.pullup_override_value     = '0;
    ovr.direction_override_enable = '0;
    ovr.direction_override_value  = '0;
    ovr.toggle_override_enable    = '0;
    ovr.pullup_override_enable[PIN_TOP]    = debug_mode; // RQ1
    ovr.pullup_override_value[PIN_TOP]     = 1'b1;
    ovr.direction_override_enable[PIN_TOP] = debug_mode;
    ovr.direction_override_value[PIN_TOP]  = debug_link_tx_i;
  end

  // port value override: compare outputs own pins one and zero
  always_comb begin
    ovr.port_value_override_enable = '0; // RQ7
    ovr.port_value_override_value  = '0;
    ovr.port_value_override_enable[PIN_CMP_NEG] = timer_compare_b_enable_i; // RQ6
    ovr.port_value_override_value[PIN_CMP_NEG]  = timer_compare_b_output_i;
    ovr.port_value_override_enable[PIN_CMP_POS] = timer_compare_a_enable_i;
    ovr.port_value_override_value[PIN_CMP_POS]  = timer_compare_a_output_i;
  end

  // digital input enable overrides, value always the disable bit
  always_comb begin
    ovr.input_enable_override_enable[PIN_TOP] = fuse_rst_off |
      input_override(pin_change_mask_i[PIN_TOP], pin_change_enable_i,
                     analog_digital_disable_i[CH0]); // RQ3
    ovr.input_enable_override_value[PIN_TOP] = analog_digital_disable_i[CH0];
    ovr.input_enable_override_enable[PIN_CH2] =
      input_override(pin_change_mask_i[PIN_CH2], pin_change_enable_i,
                     analog_digital_disable_i[CH2]); // RQ4
    ovr.input_enable_override_value[PIN_CH2] = analog_digital_disable_i[CH2];
    ovr.input_enable_override_enable[PIN_CH3] =
      input_override(pin_change_mask_i[PIN_CH3], pin_change_enable_i,
                     analog_digital_disable_i[CH3]); // RQ4
    ovr.input_enable_override_value[PIN_CH3] = analog_digital_disable_i[CH3];
    ovr.input_enable_override_enable[PIN_TIMER] =
      input_override(pin_change_mask_i[PIN_TIMER], pin_change_enable_i,
                     analog_digital_disable_i[CH1]); // RQ4
    ovr.input_enable_override_value[PIN_TIMER] = analog_digital_disable_i[CH1];
    ovr.input_enable_override_enable[PIN_CMP_NEG] =
      input_override(pin_change_mask_i[PIN_CMP_NEG], pin_change_enable_i,
                     comparator_neg_digital_disable_i); // RQ5
    ovr.input_enable_override_value[PIN_CMP_NEG] = comparator_neg_digital_disable_i;
    ovr.input_enable_override_enable[PIN_CMP_POS] =
      input_override(pin_change_mask_i[PIN_CMP_POS], pin_change_enable_i,
                     comparator_pos_digital_disable_i); // RQ5
    ovr.input_enable_override_value[PIN_CMP_POS] = comparator_pos_digital_disable_i;
  end

  pbo_pin_ctl #(.N(N)) u_pins (
    .ovr             (ovr),
    .pin_direction_i (state_ff.dir),
    .pin_output_i    (state_ff.port),
    .pullup_off_i    (state_ff.mcu[PULLUP_DISABLE_BIT]),
    .sleep_i         (sleep_i),
    .pad_i           (pad_i),
    .pad_o           (pad_o),
    .pad_oe_o        (pad_oe_o),
    .pullup_o        (pullup_o),
    .din_o           (din)
  );

  // routing of digital inputs; pin two fans out to three consumers
  assign pin_change_src_o          = din; // RQ8
  assign timer_external_clock_o    = din[PIN_TIMER]; // RQ8
  assign external_interrupt_zero_o = din[PIN_TIMER]; // RQ8
  assign external_clock_input_o    = din[PIN_CH3]; // RQ10
  assign debug_link_io_o           = din[PIN_TOP]; // RQ9

  // analog paths bypass the input clamp, straight from the pad
  assign reset_pin_level_o         = pad_i[PIN_TOP]; // RQ9
  assign analog_channel_o[CH0]     = pad_i[PIN_TOP]; // RQ9
  assign analog_channel_o[CH1]     = pad_i[PIN_TIMER];
  assign analog_channel_o[CH2]     = pad_i[PIN_CH2];
  assign analog_channel_o[CH3]     = pad_i[PIN_CH3]; // RQ10
  assign comparator_pos_o          = pad_i[PIN_CMP_POS]; // RQ10
  assign comparator_neg_o          = pad_i[PIN_CMP_NEG]; // RQ10
  assign global_pullup_disable_o   = state_ff.mcu[PULLUP_DISABLE_BIT];

  assign req = wb_cyc_i & wb_stb_i;

  // bus and register state; a write commits on the edge the master sees ack,
  // so software never observes a register change before its cycle ends
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.pins = pad_i;
    nxt_state.ack  = req & ~state_ff.ack;
    if (req & ~state_ff.ack) begin
      nxt_state.rdata = wb_we_i ? '0 : reg_read(state_ff, wb_adr_i);
    end
    if (req & state_ff.ack & wb_we_i & wb_sel_i[0]) begin
      unique case (wb_adr_i)
        ADDR_MCU_CONTROL: nxt_state.mcu  = wb_dat_i[REG_WIDTH-1:0] & MCU_WR_MASK; // RQ12
        ADDR_PORT_OUTPUT: nxt_state.port = wb_dat_i[N-1:0]; // RQ13
        ADDR_DIRECTION:   nxt_state.dir  = wb_dat_i[N-1:0];
        default:          nxt_state.pins = pad_i; // read-only or unmapped
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{ack: 1'b0, rdata: '0, mcu: MCU_RESET, port: PORT_RESET,
                    dir: DIR_RESET, pins: '0}; // RQ12 RQ13
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wb_ack_o = state_ff.ack;
  assign wb_dat_o = state_ff.rdata;

  // checks

  a_debug_pullup: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    (!reset_pin_disable_fuse_i && !debug_link_enable_fuse_i) |->
      pullup_o[PIN_TOP] && pad_oe_o[PIN_TOP] == debug_link_tx_i)
    else $error("debug mode pull-up or direction wrong");

  a_fuse_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    (reset_pin_disable_fuse_i || debug_link_enable_fuse_i) |->
      !ovr.pullup_override_enable[PIN_TOP])
    else $error("unprogrammed fuse enabled an override");

  // input enable overrides
  a_top_input_ovr: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    ovr.input_enable_override_enable[PIN_TOP] == (!reset_pin_disable_fuse_i ||
      (pin_change_mask_i[PIN_TOP] && pin_change_enable_i) ||
      analog_digital_disable_i[CH0]))
    else $error("top pin input override enable wrong");

  a_top_input_val: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    ovr.input_enable_override_value[PIN_TOP] == analog_digital_disable_i[CH0])
    else $error("top pin input override value wrong");

  a_timer_pin_ovr: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
    ovr.input_enable_override_enable[PIN_TIMER] ==
      ((pin_change_mask_i[PIN_TIMER] && pin_change_enable_i) ||
       analog_digital_disable_i[CH1]) &&
    ovr.input_enable_override_value[PIN_TIMER] ==
      analog_digital_disable_i[CH1])
    else $error("pin two input override wrong");

  a_cmp_input_ovr: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
    comparator_pos_digital_disable_i |->
      ovr.input_enable_override_enable[PIN_CMP_POS] &&
      ovr.input_enable_override_value[PIN_CMP_POS])
    else $error("comparator disable not overriding input");

  a_compare_drive: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6 RQ16
    (timer_compare_a_enable_i && pad_oe_o[PIN_CMP_POS]) |->
      pad_o[PIN_CMP_POS] == timer_compare_a_output_i)
    else $error("compare A waveform not on pin zero");

  a_compare_b_drive: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6 RQ16
    (timer_compare_b_enable_i && pad_oe_o[PIN_CMP_NEG]) |->
      pad_o[PIN_CMP_NEG] == timer_compare_b_output_i)
    else $error("compare B waveform not on pin one");

  a_idle_overrides: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
    ovr.toggle_override_enable == '0 &&
    ovr.port_value_override_enable[PIN_TOP:PIN_TIMER] == '0)
    else $error("unexpected override active");

  a_pin_two_route: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    timer_external_clock_o == pin_change_src_o[PIN_TIMER] &&
    external_interrupt_zero_o == pin_change_src_o[PIN_TIMER])
    else $error("pin two routing mismatch");

  // pin routing
  a_top_routes: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
    reset_pin_level_o == pad_i[PIN_TOP] &&
    analog_channel_o[CH0] == pad_i[PIN_TOP] &&
    debug_link_io_o == pin_change_src_o[PIN_TOP])
    else $error("top pin routing mismatch");

  a_other_routes: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    comparator_pos_o == pad_i[PIN_CMP_POS] &&
    comparator_neg_o == pad_i[PIN_CMP_NEG] &&
    analog_channel_o[CH3] == pad_i[PIN_CH3] &&
    external_clock_input_o == pin_change_src_o[PIN_CH3])
    else $error("clock or comparator routing mismatch");

  a_pullup_disable: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
    (state_ff.mcu[PULLUP_DISABLE_BIT] && !debug_mode) |-> pullup_o == '0)
    else $error("pull-up on while globally disabled");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
    (wb_ack_o && $past(wb_adr_i) == ADDR_MCU_CONTROL && !$past(wb_we_i)) |->
      (wb_dat_o[REG_WIDTH-1:0] & ~MCU_WR_MASK) == '0)
    else $error("reserved control bits read nonzero");

  a_port_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
    (wb_ack_o && $past(wb_adr_i) == ADDR_PORT_OUTPUT && !$past(wb_we_i)) |->
      wb_dat_o[WB_DW-1:N] == '0)
    else $error("output register upper bits read nonzero");

  a_port_write: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
    (req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_PORT_OUTPUT)
      |=> state_ff.port == $past(wb_dat_i[N-1:0]) ##1 !wb_ack_o)
    else $error("output register write not taken");

  a_pullup_normal: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
    !debug_mode |-> pullup_o == (~state_ff.dir & state_ff.port &
      {N{~state_ff.mcu[PULLUP_DISABLE_BIT]}}))
    else $error("pull-up equation wrong");

  a_direction: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
    !debug_mode |-> pad_oe_o == state_ff.dir)
    else $error("driver enable not from direction bits");

  a_input_sleep: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    (sleep_i && !ovr.input_enable_override_enable[PIN_CH2]) |->
      !pin_change_src_o[PIN_CH2])
    else $error("input not clamped in sleep");

  a_input_awake: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    (!sleep_i && !ovr.input_enable_override_enable[PIN_CH2]) |->
      pin_change_src_o[PIN_CH2] == pad_i[PIN_CH2])
    else $error("input clamped while awake");

endmodule
`default_nettype wire

/* verif/pbo_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
// stand-in for the peripherals that steer the port: fuses, debug link,
// pin change, analog and comparator disables, timer compare units
module pbo_periph_model (
  input  wire logic        clk_i,    // i/o clock
  input  wire logic        rst_i,    // synchronous reset, high
  input  wire logic [16:0] cmd_i,    // wanted setup, applied one cycle later
  output logic      [16:0] state_o,  // applied setup, bits 1:0 stored fuses
  output logic             dbg_tx_o, // debug transmit bit stream
  output logic             cmp_a_o,  // compare A waveform
  output logic             cmp_b_o   // compare B waveform
);
  logic [1:0] cnt_ff;

  // the two waveforms run at different rates so swapped pins show up
  assign cmp_a_o  = state_o[15] & cnt_ff[0];
  assign cmp_b_o  = state_o[16] & cnt_ff[1];
  assign dbg_tx_o = cnt_ff[0];

  // fuses leave reset erased (stored one); setup lags the request a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o <= 17'h00003;
      cnt_ff  <= 2'h0;
    end else begin
      state_o <= cmd_i;
      cnt_ff  <= cnt_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* verif/pbo_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pbo_top_tb
  import pbo_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, sleep, ack, tx, ca, cb;
  logic        dbg_io, rst_lvl, tclk, external_interrupt_zero, xclk, cpos, cneg, gpd;
  logic [3:0]  adr, an;
  logic [31:0] wdat, rdat;
  logic [16:0] cmd, st;
  logic [5:0]  ext, pad_w, pad_o, oe, pu, src;
  logic [7:0]  q;
  int          fails, n_checks;
  int          dbit [6] = '{13, 14, 10, 12, 11, 9};

  // pad level: our driver wins where enabled, else the outside world
  assign pad_w = (oe & pad_o) | (~oe & ext);

  pbo_periph_model i_periph (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .state_o(st),
    .dbg_tx_o(tx), .cmp_a_o(ca), .cmp_b_o(cb));

  pbo_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .reset_pin_disable_fuse_i(st[0]), .debug_link_enable_fuse_i(st[1]),
    .debug_link_tx_i(tx), .pin_change_mask_i(st[7:2]), .pin_change_enable_i(st[8]),
    .analog_digital_disable_i(st[12:9]), .comparator_pos_digital_disable_i(st[13]),
    .comparator_neg_digital_disable_i(st[14]), .timer_compare_a_enable_i(st[15]),
    .timer_compare_a_output_i(ca), .timer_compare_b_enable_i(st[16]),
    .timer_compare_b_output_i(cb), .sleep_i(sleep), .pad_i(pad_w), .pad_o(pad_o),
    .pad_oe_o(oe), .pullup_o(pu), .pin_change_src_o(src), .timer_external_clock_o(tclk),
    .external_interrupt_zero_o(external_interrupt_zero), .external_clock_input_o(xclk),
    .debug_link_io_o(dbg_io), .reset_pin_level_o(rst_lvl), .analog_channel_o(an),
    .comparator_pos_o(cpos), .comparator_neg_o(cneg), .global_pullup_disable_o(gpd));

  // free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  // classic single cycle; waits up to 50 cycles for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      fails++;
      $display("[ERR] %0t no acknowledge", $time);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic setc(input logic [16:0] v);
    @(posedge clk_i);
    cmd <= v;
    settle;
  endtask

  task automatic t_regs;
    wb(1'b0, ADDR_MCU_CONTROL, 8'h00);
    chk(q, 8'h00, "control reset");
    wb(1'b0, ADDR_PORT_OUTPUT, 8'h00);
    chk(q, 8'h00, "output reset");
    wb(1'b1, ADDR_MCU_CONTROL, 8'hFF);
    wb(1'b0, ADDR_MCU_CONTROL, 8'h00);
    chk(q, 8'h7B, "control reserved bits");
    wb(1'b1, ADDR_PORT_OUTPUT, 8'hFF);
    wb(1'b0, ADDR_PORT_OUTPUT, 8'h00);
    chk(q, 8'h3F, "output upper bits");
    wb(1'b0, 4'h2, 8'h00);
    chk(q, 8'h00, "unmapped read");
  endtask

  // pull-ups against direction, output bit and the global disable
  task automatic t_pull;
    settle;
    chk(pu, 6'h00, "global disable");
    chk(gpd, 1'b1, "disable bit out");
    wb(1'b1, ADDR_MCU_CONTROL, 8'h00);
    wb(1'b1, ADDR_DIRECTION, 8'h0F);
    settle;
    chk(pu, 6'h30, "pull-up inputs only");
    chk(oe, 6'h0F, "driver from direction");
    chk(pad_o, 6'h3F, "driven from output bits");
  endtask

  task automatic t_debug;
    wb(1'b1, ADDR_MCU_CONTROL, 8'h40);
    setc(17'h00000);
    repeat (2) begin
      @(negedge clk_i);
      chk(pu, 6'h20, "debug pull-up");
      chk(oe, {tx, 5'h0F}, "debug direction");
    end
    setc(17'h00002);
    chk(pu, 6'h00, "one fuse only");
    chk(oe, 6'h0F, "one fuse direction");
    wb(1'b1, ADDR_MCU_CONTROL, 8'h00);
  endtask

  task automatic t_timer;
    wb(1'b1, ADDR_PORT_OUTPUT, 8'h00);
    wb(1'b1, ADDR_DIRECTION, 8'h03);
    setc(17'h18003);
    repeat (4) begin
      @(negedge clk_i);
      chk(pad_o, {4'h0, cb, ca}, "compare outputs");
    end
    setc(17'h00003);
    wb(1'b1, ADDR_PORT_OUTPUT, 8'h03);
    settle;
    chk(pad_o, 6'h03, "compare released");
  endtask

  // input enable overrides while asleep, then awake
  task automatic t_input;
    wb(1'b1, ADDR_DIRECTION, 8'h00);
    @(posedge clk_i);
    sleep <= 1'b1;
    ext   <= 6'h3F;
    setc(17'h00003);
    chk(src, 6'h00, "sleep clamp");
    for (int p = 0; p < 6; p++) begin
      setc(17'h00003 | (17'h1 << dbit[p]));
      chk(src, 6'h01 << p, "disable bit override");
    end
    @(posedge clk_i);
    sleep <= 1'b0;
    setc(17'h001FF);
    chk(src, 6'h00, "masked pin change");
    setc(17'h000FF);
    chk(src, 6'h3F, "mask without enable");
    setc(17'h00002);
    chk(src, 6'h1F, "reset pin disabled");
  endtask

  task automatic t_route;
    logic [5:0] pats [2] = '{6'h15, 6'h2A};
    setc(17'h00003);
    foreach (pats[i]) begin
      @(posedge clk_i);
      ext <= pats[i];
      @(negedge clk_i);
      chk(src, pats[i], "pin change sources");
      chk({tclk, external_interrupt_zero}, {2{pats[i][2]}}, "pin two routes");
      chk({dbg_io, rst_lvl}, {2{pats[i][5]}}, "top pin routes");
      chk(an, {pats[i][3], pats[i][4], pats[i][2], pats[i][5]}, "analog");
      chk({xclk, cneg, cpos}, {pats[i][3], pats[i][1:0]}, "clock, comparator");
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_sim;
  end

  // main sequence
  initial begin
    {rst_i, cyc, stb, we, sleep, adr, wdat, ext} = '0;
    rst_i    = 1'b1;
    cmd      = 17'h00003;
    fails    = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_pull;
    t_debug;
    t_timer;
    t_input;
    t_route;
    end_sim;
  end
endmodule
`default_nettype wire
